/* File: verilog/adc_conversion_config_ctrl.sv */
// converter control: registers, trigger select, timing, result alignment, dma request
// Behaviour
// - result placement in data register follows one alignment bit of control register one
// - 6-bit resolution uses its own alignment layout
// - each channel owns a 3-bit sample time field used when sampling it
// - at 12-bit, sample plus conversion equals sample time plus 12.5 cycles
// - conversions start on rising edges of trigger input or software start only
// - trigger source bit 0 selects trigger input, 1 selects software start
// - with dma enabled, one dma request at end of each routine conversion
// - second converter instance never raises a dma request
// - temp sensor enable connects sensor to channel 16, clear powers it down
// - reference enable connects bandgap reference to channel 17 of first converter
// - results are 12 bits wide, unused low bits read as zero
// - conversion takes 12.5/10.5/8.5/6.5 cycles, sample time at least 2.5
// - converter off holds logic in reset and powers analog part down
// - each conversion stores result, sets end flag, interrupts if enabled
//
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/1ns
module adc_conversion_config_ctrl #(
  parameter int HALF_DIV      = adc_ctrl_pkg::HALF_DIV_DEFAULT,
  parameter bit SECOND_INST   = 1'b0
) (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  input  wire logic        trigger_matrix_input_i,
  input  wire logic [11:0] adc_raw_i,
  output logic      [4:0]  chan_sel_o,
  output logic             sample_o,
  output logic             analog_power_down_o,
  output logic             temp_sensor_on_o,
  output logic             int_ref_on_o,
  output logic             dma_req_o,
  output logic             eoc_irq_o
);

  adc_ctrl_pkg::ctl_one_t ctl, next_ctl;
  logic [31:0] sampt_a, next_sampt_a;
  logic [31:0] sampt_b, next_sampt_b;
  logic [1:0]  res, next_res;
  logic [4:0]  chan, next_chan;
  logic [15:0] rdata, next_rdata;
  logic        eoc, next_eoc;
  logic [31:0] rd_val, next_rd_val;

  adc_ctrl_pkg::conv_state_t state, next_state;
  logic [9:0]  cnt, next_cnt;
  logic        trig_q, next_trig_q;
  logic        sw_q, next_sw_q;
  logic        dma_req, next_dma_req;
  logic        sample, next_sample;
  logic [$clog2(HALF_DIV)-1:0] div, next_div;

  // divider reload; a trigger also reloads it so every phase spans whole half cycles
  localparam logic [$clog2(HALF_DIV)-1:0] DIV_LOAD = $clog2(HALF_DIV)'(HALF_DIV - 1);

  logic [2:0]  chan_st [adc_ctrl_pkg::CHANNELS];
  logic [2:0]  cur_st;
  logic        half_tick;
  logic        trig_edge;
  logic        conv_end;
  logic [9:0]  conv_half;
  logic [11:0] masked;
  logic [15:0] aligned;
  logic [4:0]  next_chan_sel;
  logic        next_power_down;
  logic        next_temp_on;
  logic        next_ref_on;
  logic        next_irq;

  // per-channel sample time fields, channels 0..9 in register a, the rest in b
  for (genvar g = 0; g < adc_ctrl_pkg::CHANNELS; g++) begin : g_st
    if (g < adc_ctrl_pkg::SAMPT_A_CHANS) begin : g_a
      assign chan_st[g] = sampt_a[g*adc_ctrl_pkg::STF_W +: adc_ctrl_pkg::STF_W];
    end else begin : g_b
      assign chan_st[g] =
        sampt_b[(g-adc_ctrl_pkg::SAMPT_A_CHANS)*adc_ctrl_pkg::STF_W +: adc_ctrl_pkg::STF_W];
    end
  end

  // channel numbers past the last input own no sample field; they get the shortest time
  always_comb begin
    cur_st = 3'h0;
    if (chan < 5'(adc_ctrl_pkg::CHANNELS)) begin
      cur_st = chan_st[chan];
    end
  end

  assign half_tick = (div == '0);

  // only the selected source counts, and only its low-to-high step
  assign trig_edge = ctl.trig_src_sw ? (ctl.sw_start & ~sw_q)
                                     : (trigger_matrix_input_i & ~trig_q);

  assign conv_end = (state == adc_ctrl_pkg::CONVERT) && half_tick && (cnt == 10'h001);

  always_comb begin
    case (res)
      adc_ctrl_pkg::RES_12: conv_half = adc_ctrl_pkg::CONV_HALF_12;
      adc_ctrl_pkg::RES_10: conv_half = adc_ctrl_pkg::CONV_HALF_10;
      adc_ctrl_pkg::RES_8:  conv_half = adc_ctrl_pkg::CONV_HALF_8;
      default:              conv_half = adc_ctrl_pkg::CONV_HALF_6;
    endcase
  end

  // unused low bits are forced to zero, then placed by the alignment bit
  always_comb begin
    case (res)
      adc_ctrl_pkg::RES_12: masked = adc_raw_i;
      adc_ctrl_pkg::RES_10: masked = {adc_raw_i[11:2], 2'h0};
      adc_ctrl_pkg::RES_8:  masked = {adc_raw_i[11:4], 4'h0};
      default:              masked = {adc_raw_i[11:6], 6'h00};
    endcase
    if (res == adc_ctrl_pkg::RES_6) begin
      aligned = ctl.align_left ? {8'h00, masked[11:6], 2'h0}
                               : {10'h000, masked[11:6]};
    end else begin
      aligned = ctl.align_left ? {masked, 4'h0} : {4'h0, masked};
    end
  end

  // register file
  always_comb begin
    next_ctl     = ctl;
    next_sampt_a = sampt_a;
    next_sampt_b = sampt_b;
    next_res     = res;
    next_chan    = chan;
    next_rdata   = rdata;
    next_eoc     = eoc;
    next_rd_val  = 32'h0000_0000;
    if (wr_i) begin
      case (addr_i)
        adc_ctrl_pkg::CTL_ONE_OFS:  next_ctl     = adc_ctrl_pkg::ctl_one_t'(wdata_i[7:0]);
        adc_ctrl_pkg::SAMPT_A_OFS:  next_sampt_a = {2'h0, wdata_i[29:0]};
        adc_ctrl_pkg::SAMPT_B_OFS:  next_sampt_b = {8'h00, wdata_i[23:0]};
        adc_ctrl_pkg::OVS_CTRL_OFS: next_res     = wdata_i[adc_ctrl_pkg::RES_LSB +: 2];
        adc_ctrl_pkg::CHAN_SEL_OFS: next_chan    = wdata_i[4:0];
        adc_ctrl_pkg::STAT_OFS: begin
          if (!wdata_i[adc_ctrl_pkg::EOC_BIT]) begin
            next_eoc = 1'b0;
          end
        end
        default: ;
      endcase
    end
    // a started conversion consumes the software start bit
    if (state == adc_ctrl_pkg::IDLE && trig_edge && ctl.trig_src_sw) begin
      next_ctl.sw_start = 1'b0;
    end
    // set after the software clear so a result landing in the same cycle is never lost
    if (conv_end) begin
      next_rdata = aligned;
      next_eoc   = 1'b1;
    end
    if (!ctl.conv_on) begin
      next_ctl.sw_start = 1'b0;
    end
    // reads have no side effects; an unmapped offset reads as zero
    if (rd_i) begin
      case (addr_i)
        adc_ctrl_pkg::STAT_OFS:     next_rd_val = {31'h0, eoc};
        adc_ctrl_pkg::CTL_ONE_OFS:  next_rd_val = {24'h0, ctl};
        adc_ctrl_pkg::SAMPT_A_OFS:  next_rd_val = sampt_a;
        adc_ctrl_pkg::SAMPT_B_OFS:  next_rd_val = sampt_b;
        adc_ctrl_pkg::RDATA_OFS:    next_rd_val = {16'h0, rdata};
        adc_ctrl_pkg::OVS_CTRL_OFS: next_rd_val = {30'h0, res};
        adc_ctrl_pkg::CHAN_SEL_OFS: next_rd_val = {27'h0, chan};
        default:                    next_rd_val = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctl     <= adc_ctrl_pkg::ctl_one_t'(adc_ctrl_pkg::CTL_ONE_RST[7:0]);
      sampt_a <= adc_ctrl_pkg::SAMPT_RST;
      sampt_b <= adc_ctrl_pkg::SAMPT_RST;
      res     <= adc_ctrl_pkg::RES_RST;
      chan    <= 5'h00;
      rdata   <= 16'h0000;
      eoc     <= 1'b0;
      rd_val  <= 32'h0000_0000;
    end else begin
      ctl     <= next_ctl;
      sampt_a <= next_sampt_a;
      sampt_b <= next_sampt_b;
      res     <= next_res;
      chan    <= next_chan;
      rdata   <= next_rdata;
      eoc     <= next_eoc;
      rd_val  <= next_rd_val;
    end
  end

  // sequencer: sample phase then conversion phase, counted in half converter cycles
  always_comb begin
    next_state   = state;
    next_cnt     = cnt;
    next_trig_q  = trigger_matrix_input_i;
    next_sw_q    = ctl.sw_start;
    next_dma_req = 1'b0;
    next_sample  = 1'b0;
    next_div     = half_tick ? DIV_LOAD : div - 1'b1;
    case (state)
      adc_ctrl_pkg::IDLE: begin
        if (trig_edge) begin
          next_state  = adc_ctrl_pkg::SAMPLE;
          next_cnt    = adc_ctrl_pkg::sample_half(cur_st);
          next_sample = 1'b1;
          next_div    = DIV_LOAD;
        end
      end
      adc_ctrl_pkg::SAMPLE: begin
        next_sample = 1'b1;
        if (half_tick) begin
          next_cnt = cnt - 10'h001;
          if (cnt == 10'h001) begin
            next_state  = adc_ctrl_pkg::CONVERT;
            next_cnt    = conv_half;
            next_sample = 1'b0;
          end
        end
      end
      adc_ctrl_pkg::CONVERT: begin
        if (half_tick) begin
          next_cnt = cnt - 10'h001;
          if (cnt == 10'h001) begin
            next_state   = adc_ctrl_pkg::IDLE;
            // the second instance has no dma path at all
            next_dma_req = ctl.dma_en && !SECOND_INST;
          end
        end
      end
      default: next_state = adc_ctrl_pkg::IDLE;
    endcase
    // switching the converter off aborts a conversion in flight and drops its request
    if (!ctl.conv_on) begin
      next_state   = adc_ctrl_pkg::IDLE;
      next_cnt     = 10'h000;
      next_sample  = 1'b0;
      next_dma_req = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state   <= adc_ctrl_pkg::IDLE;
      cnt     <= 10'h000;
      trig_q  <= 1'b0;
      sw_q    <= 1'b0;
      dma_req <= 1'b0;
      sample  <= 1'b0;
      div     <= '0;
    end else begin
      state   <= next_state;
      cnt     <= next_cnt;
      trig_q  <= next_trig_q;
      sw_q    <= next_sw_q;
      dma_req <= next_dma_req;
      sample  <= next_sample;
      div     <= next_div;
    end
  end

  // analog-side controls follow the register values they will hold next cycle
  always_comb begin
    next_chan_sel   = next_chan;
    next_power_down = !next_ctl.conv_on;
    next_temp_on    = next_ctl.temp_en;
    // the bandgap only reaches channel 17 on the first converter
    next_ref_on     = next_ctl.ref_en && !SECOND_INST;
    next_irq        = next_eoc && next_ctl.done_ie;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      chan_sel_o          <= 5'h00;
      analog_power_down_o <= 1'b1;
      temp_sensor_on_o    <= 1'b0;
      int_ref_on_o        <= 1'b0;
      eoc_irq_o           <= 1'b0;
    end else begin
      chan_sel_o          <= next_chan_sel;
      analog_power_down_o <= next_power_down;
      temp_sensor_on_o    <= next_temp_on;
      int_ref_on_o        <= next_ref_on;
      eoc_irq_o           <= next_irq;
    end
  end

  assign rdata_o   = rd_val;
  assign dma_req_o = dma_req;
  assign sample_o  = sample;

endmodule // adc_conversion_config_ctrl

/* File: verilog/adc_ctrl_pkg.sv */
// shared constants, register map and types of the converter control block
package adc_ctrl_pkg;
  // register byte offsets
  localparam logic [7:0] STAT_OFS       = 8'h00;
  localparam logic [7:0] CTL_ONE_OFS    = 8'h04;
  localparam logic [7:0] SAMPT_A_OFS    = 8'h08;
  localparam logic [7:0] SAMPT_B_OFS    = 8'h0C;
  localparam logic [7:0] RDATA_OFS      = 8'h10;
  localparam logic [7:0] OVS_CTRL_OFS   = 8'h14;
  localparam logic [7:0] CHAN_SEL_OFS   = 8'h18;
  // control register one field positions, then status and resolution field positions and channel layout
  localparam int CONV_ON_BIT    = 0;
  localparam int SW_START_BIT   = 1;
  localparam int TRIG_SRC_BIT   = 2;
  localparam int ALIGN_BIT      = 3;
  localparam int DMA_EN_BIT     = 4;
  localparam int TEMP_EN_BIT    = 5;
  localparam int REF_EN_BIT     = 6;
  localparam int DONE_IE_BIT    = 7;
  localparam int EOC_BIT        = 0;
  localparam int RES_LSB        = 0;
  localparam int CHANNELS       = 18;
  localparam int STF_W          = 3;
  localparam int SAMPT_A_CHANS  = 10;
  localparam logic [4:0] TEMP_CHAN = 5'h10;
  localparam logic [4:0] REF_CHAN  = 5'h11;
  // reset values
  localparam logic [31:0] CTL_ONE_RST = 32'h0000_0000;
  localparam logic [31:0] SAMPT_RST   = 32'h0000_0000;
  localparam logic [1:0]  RES_RST     = 2'h0;
  // resolution codes
  localparam logic [1:0] RES_12 = 2'h0;
  localparam logic [1:0] RES_10 = 2'h1;
  localparam logic [1:0] RES_8  = 2'h2;
  localparam logic [1:0] RES_6  = 2'h3;
  // converter clock: system cycles per half converter cycle (250 MHz / 16 = 15.6 MHz)
  localparam int HALF_DIV_DEFAULT = 8;
  // conversion phase in half converter cycles: 12.5, 10.5, 8.5, 6.5 cycles
  localparam logic [9:0] CONV_HALF_12 = 10'h019;
  localparam logic [9:0] CONV_HALF_10 = 10'h015;
  localparam logic [9:0] CONV_HALF_8  = 10'h011;
  localparam logic [9:0] CONV_HALF_6  = 10'h00D;

  typedef struct packed {
    logic done_ie;
    logic ref_en;
    logic temp_en;
    logic dma_en;
    logic align_left;
    logic trig_src_sw;
    logic sw_start;
    logic conv_on;
  } ctl_one_t;

  typedef enum logic [1:0] {IDLE, SAMPLE, CONVERT} conv_state_t;

  // sample time code to half converter cycles: 2.5 .. 479.5 cycles
  function automatic logic [9:0] sample_half(input logic [2:0] code);
    case (code)
      3'h0:    sample_half = 10'h005;
      3'h1:    sample_half = 10'h01D;
      3'h2:    sample_half = 10'h037;
      3'h3:    sample_half = 10'h06F;
      3'h4:    sample_half = 10'h0A7;
      3'h5:    sample_half = 10'h0DF;
      3'h6:    sample_half = 10'h11F;
      default: sample_half = 10'h3BF;
    endcase
  endfunction
endpackage

/* File: dv/adc_ctrl_checker.sv */
// concurrent checks on the converter control block ports
`timescale 1ns/1ns
module adc_ctrl_checker #(
  parameter int HALF_DIV    = 8,
  parameter bit SECOND_INST = 1'b0
) (
  input wire logic        sys_clk_i,
  input wire logic        rst_n_i,
  input wire logic [7:0]  addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic [4:0]  chan_sel_o,
  input wire logic        sample_o,
  input wire logic        analog_power_down_o,
  input wire logic        temp_sensor_on_o,
  input wire logic        int_ref_on_o,
  input wire logic        dma_req_o,
  input wire logic        eoc_irq_o
);
  logic       ctl_wr;
  logic [2:0] ctl_bits;
  logic [2:0] next_ctl_bits;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // shadow of irq enable, reference and sensor enables as last written
  always_comb begin
    ctl_wr        = wr_i && addr_i == adc_ctrl_pkg::CTL_ONE_OFS;
    next_ctl_bits = ctl_wr ? wdata_i[7:5] : ctl_bits;
  end
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctl_bits <= 3'h0;
    end else begin
      ctl_bits <= next_ctl_bits;
    end
  end
  property p_dma_one; dma_req_o |=> !dma_req_o; endproperty
  a_dma_one: assert property (p_dma_one) else $error("dma request longer than one cycle");
  property p_second; !(SECOND_INST && (dma_req_o || int_ref_on_o)); endproperty
  a_second: assert property (p_second) else $error("second instance drives dma or reference");
  property p_rd_idle; !rd_i |=> rdata_o == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without a read strobe");
  property p_off_pd; ctl_wr && !wdata_i[0] |-> ##[1:2] analog_power_down_o; endproperty
  a_off_pd: assert property (p_off_pd) else $error("analog part not powered down when off");
  property p_pd_quiet; analog_power_down_o && $past(analog_power_down_o) |-> !sample_o; endproperty
  a_pd_quiet: assert property (p_pd_quiet) else $error("sampling while powered down");
  property p_temp; ctl_wr |=> ##[0:1] temp_sensor_on_o == ctl_bits[0]; endproperty
  a_temp: assert property (p_temp) else $error("sensor connect differs from enable");
  property p_ref; ctl_wr |=> ##[0:1] int_ref_on_o == (ctl_bits[1] && !SECOND_INST); endproperty
  a_ref: assert property (p_ref) else $error("reference connect differs from enable");
  property p_sample_min; $rose(sample_o) |-> sample_o [*8]; endproperty
  a_sample_min: assert property (p_sample_min) else $error("sample phase too short");
  property p_chan_hold; sample_o && $past(sample_o) |-> $stable(chan_sel_o); endproperty
  a_chan_hold: assert property (p_chan_hold) else $error("channel moved while sampling");
  property p_irq_en; $rose(eoc_irq_o) |-> ctl_bits[2]; endproperty
  a_irq_en: assert property (p_irq_en) else $error("interrupt raised while disabled");
endmodule // adc_ctrl_checker

/* File: dv/adc_far_side_model.sv */
// trigger source and dma controller facing the converter control block
`timescale 1ns/1ns
module adc_far_side_model (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       fire_i,
  input  wire logic [7:0] hold_i,
  input  wire logic       dma_req_i,
  output logic            trig_o,
  output int              dma_count_o
);
  logic [7:0] left;
  // trigger stays high for hold_i cycles so a held level can be seen not to retrigger
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      trig_o      <= 1'b0;
      left        <= 8'h00;
      dma_count_o <= 0;
    end else begin
      if (fire_i && left == 8'h00) begin
        trig_o <= 1'b1;
        left   <= hold_i;
      end else if (left > 8'h01) begin
        left <= left - 8'h01;
      end else if (left == 8'h01) begin
        trig_o <= 1'b0;
        left   <= 8'h00;
      end
      if (dma_req_i) begin
        dma_count_o <= dma_count_o + 1;
      end
    end
  end
endmodule // adc_far_side_model

/* File: dv/tb_adc_conversion_config_ctrl.sv */
// self-checking bench of the converter control block
`timescale 1ns/1ns
module tb_adc_conversion_config_ctrl;
  // converter clock 250 MHz / (2 * 25) = 5 MHz, the most the sensor channel may see
  localparam int HALF_DIV = 25;
  logic        sys_clk_i = 1'b0;
  logic        rst_n_i   = 1'b0;
  logic [7:0]  addr_i    = 8'h00;
  logic [31:0] wdata_i   = 32'h0;
  logic        wr_i      = 1'b0;
  logic        rd_i      = 1'b0;
  logic [11:0] adc_raw_i = 12'h000;
  logic        fire      = 1'b0;
  logic [31:0] rdata_o;
  logic [31:0] d;
  logic [4:0]  chan_sel_o;
  logic        trig, sample_o, analog_power_down_o, temp_sensor_on_o, int_ref_on_o;
  logic        dma_req_o, eoc_irq_o;
  int          dmas;
  int          fail_count = 0;
  int          n_compared = 0;
  logic        dma_req_b;
  logic        int_ref_b;
  logic        seen_b     = 1'b0;
  logic [31:0] exp_q [$];
  always #2 sys_clk_i = ~sys_clk_i;
  adc_conversion_config_ctrl #(.HALF_DIV(HALF_DIV)) u_adc_conversion_config_ctrl (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .trigger_matrix_input_i(trig),
    .adc_raw_i(adc_raw_i), .chan_sel_o(chan_sel_o), .sample_o(sample_o),
    .analog_power_down_o(analog_power_down_o), .temp_sensor_on_o(temp_sensor_on_o),
    .int_ref_on_o(int_ref_on_o), .dma_req_o(dma_req_o), .eoc_irq_o(eoc_irq_o));
  adc_far_side_model u_adc_far_side_model (.clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .fire_i(fire), .hold_i(8'hC8), .dma_req_i(dma_req_o), .trig_o(trig), .dma_count_o(dmas));
  // second converter: shares every input, must never request dma or connect the bandgap
  adc_conversion_config_ctrl #(.HALF_DIV(HALF_DIV), .SECOND_INST(1'b1))
    u_adc_conversion_config_ctrl_b (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(), .trigger_matrix_input_i(trig),
    .adc_raw_i(adc_raw_i), .chan_sel_o(), .sample_o(), .analog_power_down_o(),
    .temp_sensor_on_o(), .int_ref_on_o(int_ref_b), .dma_req_o(dma_req_b), .eoc_irq_o());
  always @(posedge sys_clk_i) begin
    if (dma_req_b === 1'b1 || int_ref_b === 1'b1) begin
      seen_b <= 1'b1;
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk_i);
    addr_i  <= a;
    wdata_i <= v;
    wr_i    <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask
  function automatic logic [31:0] aligned(input logic [11:0] raw, input int res, input bit left);
    logic [11:0] m;
    m = raw & (12'hFFF << (2 * res));
    if (res == 3) return left ? {24'h0, m[11:6], 2'h0} : {26'h0, m[11:6]};
    return left ? {16'h0, m, 4'h0} : {20'h0, m};
  endfunction
  task automatic convert(input int res, input bit left);
    int          ts;
    int          tc;
    int          ch;
    logic [11:0] raw;
    ts  = 0;
    tc  = 0;
    ch  = res[0] ? 16 : 0;
    raw = 12'($urandom);
    for (int i = 0; i < 300 && trig === 1'b1; i++) @(posedge sys_clk_i);
    // converter off, sensor left powered so its warm-up is not repeated
    wr(adc_ctrl_pkg::CTL_ONE_OFS, 32'h20);
    wr(adc_ctrl_pkg::OVS_CTRL_OFS, 32'(res));
    wr(adc_ctrl_pkg::CHAN_SEL_OFS, 32'(ch));
    wr(adc_ctrl_pkg::CTL_ONE_OFS, 32'h0F1 | (32'(left) * 32'hC));
    adc_raw_i <= raw;
    exp_q.push_back(aligned(raw, res, left));
    fire      <= 1'b1;
    @(posedge sys_clk_i);
    fire <= 1'b0;
    check({27'h0, chan_sel_o}, 32'(ch));
    check({31'h0, int_ref_on_o}, 32'h1);
    if (left) begin
      repeat (20) @(posedge sys_clk_i);
      check({31'h0, sample_o}, 32'h0);
      wr(adc_ctrl_pkg::CTL_ONE_OFS, 32'h0FF);
    end
    for (int i = 0; i < 200 && sample_o !== 1'b1; i++) @(posedge sys_clk_i);
    while (sample_o === 1'b1 && ts < 2000) begin
      @(posedge sys_clk_i);
      ts++;
    end
    while (dma_req_o !== 1'b1 && tc < 2000) begin
      @(posedge sys_clk_i);
      tc++;
    end
    check(32'(ts), 32'(HALF_DIV * (ch == 16 ? 29 : 5)));
    check(32'(tc), 32'(HALF_DIV * (25 - 4 * res)));
    rd(adc_ctrl_pkg::RDATA_OFS, d);
    check(d, exp_q.pop_front());
    rd(adc_ctrl_pkg::STAT_OFS, d);
    check({31'h0, eoc_irq_o}, 32'h1);
    check({31'h0, d[0]}, 32'h1);
    wr(adc_ctrl_pkg::STAT_OFS, 32'h0);
    repeat (2) @(posedge sys_clk_i);
    check({31'h0, eoc_irq_o}, 32'h0);
    $display("test res %0d align %0d done", res, left);
  endtask
  task automatic test_done();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    fail_count++;
    test_done();
  end
  initial begin
    void'($urandom(81));
    repeat (10) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    check({31'h0, analog_power_down_o}, 32'h1);
    rd(adc_ctrl_pkg::CTL_ONE_OFS, d);
    check(d, adc_ctrl_pkg::CTL_ONE_RST);
    rd(adc_ctrl_pkg::SAMPT_A_OFS, d);
    check(d, adc_ctrl_pkg::SAMPT_RST);
    rd(8'h1C, d);
    check(d, 32'h0);
    // channel 0 gets the shortest code, channel 16 the next, so a wrong pick shows
    wr(adc_ctrl_pkg::SAMPT_A_OFS, 32'h0);
    wr(adc_ctrl_pkg::SAMPT_B_OFS, 32'h0004_0000);
    rd(adc_ctrl_pkg::SAMPT_B_OFS, d);
    check(d, 32'h0004_0000);
    $display("test registers done");
    // the sensor is switched on once; the first start is written while the converter is off and is dropped, so two results are thrown away unread
    wr(adc_ctrl_pkg::CHAN_SEL_OFS, 32'h10);
    repeat (3) begin
      wr(adc_ctrl_pkg::CTL_ONE_OFS, 32'hA7);
      for (int i = 0; i < 3000 && eoc_irq_o !== 1'b1; i++) @(posedge sys_clk_i);
      wr(adc_ctrl_pkg::STAT_OFS, 32'h0);
    end
    check({31'h0, temp_sensor_on_o}, 32'h1);
    $display("test sensor warm-up done");
    for (int r = 0; r < 4; r++) begin
      for (int l = 0; l < 2; l++) begin
        convert(r, l[0]);
      end
    end
    check(32'(dmas), 32'h8);
    check({31'h0, seen_b}, 32'h0);
    test_done();
  end
endmodule // tb_adc_conversion_config_ctrl
bind adc_conversion_config_ctrl adc_ctrl_checker #(.HALF_DIV(HALF_DIV),
  .SECOND_INST(SECOND_INST)) u_adc_ctrl_checker (
  .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .chan_sel_o(chan_sel_o), .sample_o(sample_o),
  .analog_power_down_o(analog_power_down_o), .temp_sensor_on_o(temp_sensor_on_o),
  .int_ref_on_o(int_ref_on_o), .dma_req_o(dma_req_o), .eoc_irq_o(eoc_irq_o));
